// ---- design/usb_evt_pkg.sv ----
// constants for the node controller event aggregation block
//******************************************************************
// Notes on behaviour
// - fifo level summary, main bit 0, set by unmasked level event, cleared on its read
// - secondary summary, main bit 1, set by masked secondary event, cleared reading it
// - transmit summary, bit 2, set by masked tx event, cleared when all tx bits clear
// - frame bit 3 set on every frame counter update, cleared reading main register
// - no-ack summary, bit 4, set by unmasked no-ack event, cleared on its read
// - lock change bit 5 set on any lock state change, cleared reading main register
// - receive summary, bit 6, set by masked rx event, cleared when all rx bits clear
// - main bit 7 reads zero; main mask bit 7 is master interrupt enable
// - main events interrupt only when mask bit set; masks reset to zero, read/write
// - wake flag, secondary bit 1, set on wake interrupt, cleared when pendings clear
// - dma bit, secondary bit 2, follows unmasked dma events
// - secondary bit 3 set on valid end of packet, cleared on read
// - secondary bit 4 set after 3 ms idle, cleared on read
// - secondary bit 5 set after 5 ms idle, cleared on read
// - secondary bit 6 set after 2.5 us single-ended zero, cleared on read
// - in suspend, non-idle bus sets secondary bit 7, cleared on read
// - secondary events reach summary only through mask; mask 7..1 reset zero
// - tx complete bits 3..0 set on IN completion, cleared on endpoint status read
// - tx underflow bits 7..4 set on underflow, cleared on endpoint status read
// - endpoint 0 underflow bit always reads zero
// - tx event reaches summary only through mask; tx mask resets zero
// - rx complete bit set on packet end or error, cleared on endpoint status read
// - rx overflow bits in upper nibble set on overrun, cleared on read
//******************************************************************
package usb_evt_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_MAIN_EV  = 8'h00;
	localparam logic [7:0] OFF_MAIN_MSK = 8'h04;
	localparam logic [7:0] OFF_SEC_FLG  = 8'h08;
	localparam logic [7:0] OFF_SEC_MSK  = 8'h0C;
	localparam logic [7:0] OFF_TX_FLG   = 8'h10;
	localparam logic [7:0] OFF_TX_MSK   = 8'h14;
	localparam logic [7:0] OFF_RX_FLG   = 8'h18;
	localparam logic [7:0] OFF_RX_MSK   = 8'h1C;
	localparam logic [7:0] REG_RESET    = 8'h00;
	// main event bit positions
	localparam int MAIN_WARN  = 0;
	localparam int MAIN_SEC   = 1;
	localparam int MAIN_TX    = 2;
	localparam int MAIN_FRAME = 3;
	localparam int MAIN_NAK   = 4;
	localparam int MAIN_LOCK  = 5;
	localparam int MAIN_RX    = 6;
	localparam int MAIN_MIE   = 7;
	// node state encodings
	localparam logic [1:0] NODE_SUSPEND = 2'h3;
	// timing
	localparam int CLK_NS    = 5;
	localparam int SE0_NS    = 2500;
	localparam int SE0_CYC   = (SE0_NS + CLK_NS - 1) / CLK_NS;
	localparam int IDLE3_US  = 3000;
	localparam int IDLE5_US  = 5000;
	localparam int IDLE3_CYC = IDLE3_US * 1000 / CLK_NS;
	localparam int IDLE5_CYC = IDLE5_US * 1000 / CLK_NS;
endpackage : usb_evt_pkg

// ---- design/usb_node_event_aggregator.sv ----
// event and interrupt aggregation with apb register access
`timescale 1ns/10ps
module usb_node_event_aggregator #(
	parameter int IDLE3_CYC = usb_evt_pkg::IDLE3_CYC,
	parameter int IDLE5_CYC = usb_evt_pkg::IDLE5_CYC
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// outside event registers and frame timer
	input  wire logic        fifoLevelPend,
	input  wire logic        fifoLevelRead,
	input  wire logic        noAckPend,
	input  wire logic        noAckRead,
	input  wire logic        dmaPend,
	input  wire logic        wakeIssued,
	input  wire logic        wakePend,
	input  wire logic        frameUpdate,
	input  wire logic        unlockedFlag,
	// bus line conditions
	input  wire logic        eopSeen,
	input  wire logic        lineIdle,
	input  wire logic        lineSe0,
	input  wire logic [1:0]  nodeState,
	// endpoint events
	input  wire logic [3:0]  txDone,
	input  wire logic [3:0]  txUnderflow,
	input  wire logic [3:0]  txStatusRead,
	input  wire logic [3:0]  rxErrOrLast,
	input  wire logic [3:0]  rxOverrun,
	input  wire logic [3:0]  rxStatusRead,
	// interrupt
	output logic             irq
);
	import usb_evt_pkg::*;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	function automatic logic anyMasked(input logic [7:0] ev, input logic [7:0] msk);
		anyMasked = |(ev & msk);
	endfunction : anyMasked

	//******************************************************************
	// apb handshake
	//******************************************************************
	logic        pready_q;
	logic        pslverr_q;
	logic [7:0]  rdByte_q;
	logic        setupRd;
	logic        setupCyc;
	logic        accWr;
	logic        accRd;
	logic        mapped;
	logic [7:0]  rdSel;
	logic [7:0]  wrByte;

	// data is sampled in setup so every output stays a flop; one access cycle
	assign setupCyc = psel && !penable;
	assign setupRd  = setupCyc && !pwrite;
	assign accWr    = psel && penable && pready_q && pwrite && !pslverr_q;
	assign accRd    = psel && penable && pready_q && !pwrite && !pslverr_q;
	assign wrByte   = pwdata[7:0];
	assign mapped   = hit(paddr, OFF_MAIN_EV) || hit(paddr, OFF_MAIN_MSK)
		|| hit(paddr, OFF_SEC_FLG) || hit(paddr, OFF_SEC_MSK)
		|| hit(paddr, OFF_TX_FLG) || hit(paddr, OFF_TX_MSK)
		|| hit(paddr, OFF_RX_FLG) || hit(paddr, OFF_RX_MSK);

	//******************************************************************
	// registers
	//******************************************************************
	logic [7:0] mainMsk_q;
	logic [7:0] secMsk_q;
	logic [7:0] transmit_event_mask_q;
	logic [7:0] rxMsk_q;
	logic [7:0] mainEv;
	logic [7:0] secFlags;
	logic [7:0] txFlags;
	logic [7:0] rxFlags;
	logic [7:1] secFlg_q;
	logic [7:1] secFlg_d;
	logic [6:0] mainFlg_q;
	logic [6:0] mainFlg_d;
	logic [3:0] txFin_q;
	logic [3:0] txUf_q;
	logic [3:0] rxEnd_q;
	logic [3:0] rxOvr_q;

	assign mainEv   = {1'b0, mainFlg_q};
	assign secFlags = {secFlg_q, 1'b0};
	assign txFlags  = {txUf_q, txFin_q};
	assign rxFlags  = {rxOvr_q, rxEnd_q};

	assign rdSel = hit(paddr, OFF_MAIN_EV)  ? mainEv :
		hit(paddr, OFF_MAIN_MSK) ? mainMsk_q :
		hit(paddr, OFF_SEC_FLG)  ? secFlags :
		hit(paddr, OFF_SEC_MSK)  ? secMsk_q :
		hit(paddr, OFF_TX_FLG)   ? txFlags :
		hit(paddr, OFF_TX_MSK)   ? transmit_event_mask_q :
		hit(paddr, OFF_RX_FLG)   ? rxFlags :
		hit(paddr, OFF_RX_MSK)   ? rxMsk_q : REG_RESET;

	always_ff @(posedge clk) begin
		if (reset) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			rdByte_q  <= REG_RESET;
		end else begin
			pready_q  <= setupCyc;
			pslverr_q <= setupCyc && !mapped;
			rdByte_q  <= setupRd ? rdSel : REG_RESET;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			mainMsk_q <= REG_RESET;
			secMsk_q  <= REG_RESET;
			transmit_event_mask_q   <= REG_RESET;
			rxMsk_q   <= REG_RESET;
		end else if (accWr) begin
			if (hit(paddr, OFF_MAIN_MSK)) mainMsk_q <= wrByte;
			if (hit(paddr, OFF_SEC_MSK))  secMsk_q  <= {wrByte[7:1], 1'b0};
			if (hit(paddr, OFF_TX_MSK))   transmit_event_mask_q   <= wrByte;
			if (hit(paddr, OFF_RX_MSK))   rxMsk_q   <= wrByte;
		end
	end

	//******************************************************************
	// clear on read: only the bits actually returned are cleared
	//******************************************************************
	logic [7:0] clrMain;
	logic [7:0] clrSec;
	logic [7:0] clrRx;

	assign clrMain = (accRd && hit(paddr, OFF_MAIN_EV)) ? rdByte_q : REG_RESET;
	assign clrSec  = (accRd && hit(paddr, OFF_SEC_FLG)) ? rdByte_q : REG_RESET;
	assign clrRx   = (accRd && hit(paddr, OFF_RX_FLG))  ? rdByte_q : REG_RESET;

	//******************************************************************
	// bus line timers
	//******************************************************************
	logic [19:0] idleCnt_q;
	logic [19:0] idleCnt_d;
	logic [9:0]  se0Cnt_q;
	logic [9:0]  se0Cnt_d;
	logic        idle3Hit;
	logic        idle5Hit;
	logic        se0Hit;
	logic        resumeHit;
	logic        busy_q;

	// counter saturates at 5 ms so each idle flag fires once per idle period
	assign idleCnt_d = !lineIdle ? 20'h00000 :
		(idleCnt_q == 20'(IDLE5_CYC)) ? idleCnt_q : idleCnt_q + 20'h00001;
	assign idle3Hit  = lineIdle && (idleCnt_q == 20'(IDLE3_CYC - 1));
	assign idle5Hit  = lineIdle && (idleCnt_q == 20'(IDLE5_CYC - 1));
	assign se0Cnt_d  = !lineSe0 ? 10'h000 :
		(se0Cnt_q == 10'(SE0_CYC)) ? se0Cnt_q : se0Cnt_q + 10'h001;
	assign se0Hit    = lineSe0 && (se0Cnt_q == 10'(SE0_CYC - 1));
	assign resumeHit = (nodeState == NODE_SUSPEND) && !lineIdle && !busy_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			idleCnt_q <= 20'h00000;
			se0Cnt_q  <= 10'h000;
			busy_q    <= 1'b0;
		end else begin
			idleCnt_q <= idleCnt_d;
			se0Cnt_q  <= se0Cnt_d;
			busy_q    <= !lineIdle;
		end
	end

	//******************************************************************
	// secondary event register
	//******************************************************************
	logic [7:3] secSet;

	assign secSet = {resumeHit, se0Hit, idle5Hit, idle3Hit, eopSeen};
	assign secFlg_d[1] = wakeIssued || (secFlg_q[1] && wakePend);
	assign secFlg_d[2] = dmaPend;
	// event in the clearing cycle survives: set beats clear
	assign secFlg_d[7:3] = secSet | (secFlg_q[7:3] & ~clrSec[7:3]);

	always_ff @(posedge clk) begin
		if (reset) begin
			secFlg_q <= 7'h00;
		end else begin
			secFlg_q <= secFlg_d;
		end
	end

	//******************************************************************
	// endpoint transmit and receive flags
	//******************************************************************
	// per-endpoint next values as nets, so one process owns each flag vector
	wire logic [3:0] txFin_d;
	wire logic [3:0] txUf_d;
	wire logic [3:0] rxEnd_d;
	wire logic [3:0] rxOvr_d;

	for (genvar i = 0; i < 4; i++) begin : g_ep
		assign txFin_d[i] = txDone[i] || (txFin_q[i] && !txStatusRead[i]);
		assign rxEnd_d[i] = rxErrOrLast[i] || (rxEnd_q[i] && !rxStatusRead[i]);
		assign rxOvr_d[i] = rxOverrun[i] || (rxOvr_q[i] && !clrRx[4+i]);
		if (i == 0) begin : g_nouf
			// store and forward endpoint cannot underflow
			assign txUf_d[i] = 1'b0;
		end else begin : g_uf
			assign txUf_d[i] = txUnderflow[i] || (txUf_q[i] && !txStatusRead[i]);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			txFin_q <= 4'h0;
			txUf_q  <= 4'h0;
			rxEnd_q <= 4'h0;
			rxOvr_q <= 4'h0;
		end else begin
			txFin_q <= txFin_d;
			txUf_q  <= txUf_d;
			rxEnd_q <= rxEnd_d;
			rxOvr_q <= rxOvr_d;
		end
	end

	//******************************************************************
	// main event summary
	//******************************************************************
	logic fifoPend_q;
	logic nakPend_q;
	logic unlocked_q;
	logic secNew;

	assign secNew = anyMasked({secFlg_d & ~secFlg_q, 1'b0}, secMsk_q);
	assign mainFlg_d[MAIN_WARN] = (fifoLevelPend && !fifoPend_q)
		|| (mainFlg_q[MAIN_WARN] && !fifoLevelRead);
	assign mainFlg_d[MAIN_SEC] = secNew
		|| (mainFlg_q[MAIN_SEC] && !(accRd && hit(paddr, OFF_SEC_FLG)));
	// summary stays until every endpoint flag behind it is gone
	assign mainFlg_d[MAIN_TX] = anyMasked(txFlags, transmit_event_mask_q)
		|| (mainFlg_q[MAIN_TX] && (|txFlags));
	assign mainFlg_d[MAIN_FRAME] = frameUpdate
		|| (mainFlg_q[MAIN_FRAME] && !clrMain[MAIN_FRAME]);
	assign mainFlg_d[MAIN_NAK] = (noAckPend && !nakPend_q)
		|| (mainFlg_q[MAIN_NAK] && !noAckRead);
	assign mainFlg_d[MAIN_LOCK] = (unlockedFlag != unlocked_q)
		|| (mainFlg_q[MAIN_LOCK] && !clrMain[MAIN_LOCK]);
	assign mainFlg_d[MAIN_RX] = anyMasked(rxFlags, rxMsk_q)
		|| (mainFlg_q[MAIN_RX] && (|rxFlags));

	logic irq_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			mainFlg_q  <= 7'h00;
			fifoPend_q <= 1'b0;
			nakPend_q  <= 1'b0;
			unlocked_q <= 1'b1;
			irq_q      <= 1'b0;
		end else begin
			mainFlg_q  <= mainFlg_d;
			fifoPend_q <= fifoLevelPend;
			nakPend_q  <= noAckPend;
			unlocked_q <= unlockedFlag;
			irq_q      <= mainMsk_q[MAIN_MIE]
				&& anyMasked(mainEv, {1'b0, mainMsk_q[6:0]});
		end
	end

	assign prdata  = {24'h000000, rdByte_q};
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign irq     = irq_q;

	//******************************************************************
	// assertions
	//******************************************************************
	property p_irq_off;
		@(posedge clk) disable iff (reset)
		!mainMsk_q[MAIN_MIE] [*2] |-> !irq_q;
	endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("irq high while master enable low");

	property p_bit7_zero;
		@(posedge clk) disable iff (reset)
		(setupRd && hit(paddr, OFF_MAIN_EV)) |=> !prdata[7] && pready;
	endproperty
	a_bit7_zero: assert property (p_bit7_zero)
		else $error("main event bit 7 read as one");

	property p_frame;
		@(posedge clk) disable iff (reset)
		frameUpdate |=> mainEv[MAIN_FRAME];
	endproperty
	a_frame: assert property (p_frame)
		else $error("frame update not flagged");

	property p_lock;
		@(posedge clk) disable iff (reset)
		$changed(unlockedFlag) |=> mainEv[MAIN_LOCK];
	endproperty
	a_lock: assert property (p_lock)
		else $error("lock change not flagged");

	property p_tx_clear;
		@(posedge clk) disable iff (reset)
		(txFlags == 8'h00 && txDone == 4'h0 && txUnderflow == 4'h0) |=> !mainEv[MAIN_TX];
	endproperty
	a_tx_clear: assert property (p_tx_clear)
		else $error("transmit summary stuck with no transmit event");

	property p_rx_clear;
		@(posedge clk) disable iff (reset)
		(rxFlags == 8'h00 && rxErrOrLast == 4'h0 && rxOverrun == 4'h0) |=> !mainEv[MAIN_RX];
	endproperty
	a_rx_clear: assert property (p_rx_clear)
		else $error("receive summary stuck with no receive event");

	property p_uf0;
		@(posedge clk) disable iff (reset)
		txUnderflow[0] |=> !txFlags[4];
	endproperty
	a_uf0: assert property (p_uf0)
		else $error("endpoint 0 underflow bit set");

	property p_se0;
		@(posedge clk) disable iff (reset)
		$rose(secFlags[6]) |-> $past(lineSe0) && $past(se0Cnt_q) == 10'(SE0_CYC - 1);
	endproperty
	a_se0: assert property (p_se0)
		else $error("bus reset flag without full single-ended zero");

	property p_sec_mask;
		@(posedge clk) disable iff (reset)
		$rose(mainEv[MAIN_SEC]) |-> $past(secMsk_q) != 8'h00;
	endproperty
	a_sec_mask: assert property (p_sec_mask)
		else $error("secondary summary set with mask clear");

	property p_dma;
		@(posedge clk) disable iff (reset)
		dmaPend |=> secFlags[2];
	endproperty
	a_dma: assert property (p_dma)
		else $error("dma bit not following dma events");
endmodule : usb_node_event_aggregator

// ---- verif/ext_event_model.sv ----
// model of the outside fifo level and no-ack event registers
`timescale 1ns/10ps
module ext_event_model (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// event set and software read strobes
	input  wire logic setFifo,
	input  wire logic readFifo,
	input  wire logic setNoAck,
	input  wire logic readNoAck,
	// towards the aggregator
	output logic      fifoLevelPend,
	output logic      fifoLevelRead,
	output logic      noAckPend,
	output logic      noAckRead
);
	logic fifoPend_q;
	logic noAckPend_q;
	// a software read empties the outside register, so pend drops with it
	always_ff @(posedge clk) begin
		if (reset) begin
			fifoPend_q  <= 1'b0;
			noAckPend_q <= 1'b0;
		end else begin
			fifoPend_q  <= setFifo | (fifoPend_q & ~readFifo);
			noAckPend_q <= setNoAck | (noAckPend_q & ~readNoAck);
		end
	end
	assign fifoLevelPend = fifoPend_q;
	assign fifoLevelRead = readFifo;
	assign noAckPend     = noAckPend_q;
	assign noAckRead     = readNoAck;
endmodule : ext_event_model

// ---- verif/usb_node_event_aggregator_bench.sv ----
// self-checking bench for the event aggregation block
`timescale 1ns/10ps
module usb_node_event_aggregator_bench;
	import usb_evt_pkg::*;
	logic        clk, reset, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        fifoLevelPend, fifoLevelRead, noAckPend, noAckRead;
	logic        setFifo, readFifo, setNoAck, readNoAck, dmaPend, wakeIssued, wakePend;
	logic        frameUpdate, unlockedFlag, eopSeen, lineIdle, lineSe0;
	logic [1:0]  nodeState;
	logic [3:0]  txDone, txUnderflow, txStatusRead, rxErrOrLast, rxOverrun, rxStatusRead;
	int          failures, cmp_count;
	// node reset hold of 100 us at 5 ns per cycle
	localparam int NODE_RST_CYC = 20000;

	// short idle counts keep the run brief
	usb_node_event_aggregator #(.IDLE3_CYC(30), .IDLE5_CYC(50)) i_dut (.clk(clk), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .fifoLevelPend(fifoLevelPend),
		.fifoLevelRead(fifoLevelRead), .noAckPend(noAckPend), .noAckRead(noAckRead),
		.dmaPend(dmaPend), .wakeIssued(wakeIssued), .wakePend(wakePend),
		.frameUpdate(frameUpdate), .unlockedFlag(unlockedFlag), .eopSeen(eopSeen),
		.lineIdle(lineIdle), .lineSe0(lineSe0), .nodeState(nodeState), .txDone(txDone),
		.txUnderflow(txUnderflow), .txStatusRead(txStatusRead), .rxErrOrLast(rxErrOrLast),
		.rxOverrun(rxOverrun), .rxStatusRead(rxStatusRead), .irq(irq));
	ext_event_model i_ext (.clk(clk), .reset(reset), .setFifo(setFifo), .readFifo(readFifo),
		.setNoAck(setNoAck), .readNoAck(readNoAck), .fifoLevelPend(fifoLevelPend),
		.fifoLevelRead(fifoLevelRead), .noAckPend(noAckPend), .noAckRead(noAckRead));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	//****************************************
	// shared tasks
	//****************************************
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 8);
		if (n >= 8) begin
			failures++;
			give_verdict;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b0, 32'h0, r, e);
		chk(r, exp);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b1, d, r, e);
	endtask : wr

	// event flags show one cycle after the input, irq one later
	task automatic settle;
		repeat (3) @(posedge clk);
	endtask : settle

	//****************************************
	// scenarios
	//****************************************
	task automatic t_registers;
		logic [31:0] r;
		logic        e;
		for (int i = 0; i < 8; i++) rd(8'(4 * i), 32'h0);
		apb(8'h20, 1'b0, 32'h0, r, e);
		chk({e, r[30:0]}, 32'h80000000);
		wr(OFF_SEC_MSK, 32'hFF);
		rd(OFF_SEC_MSK, 32'hFE);
		wr(OFF_TX_MSK, 32'hA5);
		rd(OFF_TX_MSK, 32'hA5);
		wr(OFF_MAIN_MSK, 32'hFF);
		rd(OFF_MAIN_MSK, 32'hFF);
	endtask : t_registers

	task automatic t_frame_lock;
		wr(OFF_MAIN_MSK, 32'h88);
		frameUpdate <= 1'b1;
		@(posedge clk);
		frameUpdate <= 1'b0;
		settle;
		chk({31'h0, irq}, 32'h1);
		rd(OFF_MAIN_EV, 32'h08);
		rd(OFF_MAIN_EV, 32'h00);
		settle;
		chk({31'h0, irq}, 32'h0);
		wr(OFF_MAIN_MSK, 32'h28);
		unlockedFlag <= 1'b0;
		settle;
		chk({31'h0, irq}, 32'h0);
		rd(OFF_MAIN_EV, 32'h20);
		unlockedFlag <= 1'b1;
		settle;
		rd(OFF_MAIN_EV, 32'h20);
		rd(OFF_MAIN_EV, 32'h00);
	endtask : t_frame_lock

	task automatic t_fifo_nak;
		setFifo <= 1'b1;
		setNoAck <= 1'b1;
		@(posedge clk);
		setFifo <= 1'b0;
		setNoAck <= 1'b0;
		settle;
		rd(OFF_MAIN_EV, 32'h11);
		rd(OFF_MAIN_EV, 32'h11);
		readFifo <= 1'b1;
		@(posedge clk);
		readFifo <= 1'b0;
		settle;
		rd(OFF_MAIN_EV, 32'h10);
		readNoAck <= 1'b1;
		@(posedge clk);
		readNoAck <= 1'b0;
		settle;
		rd(OFF_MAIN_EV, 32'h00);
	endtask : t_fifo_nak

	task automatic t_transmit;
		wr(OFF_TX_MSK, 32'hFF);
		txDone <= 4'h2;
		txUnderflow <= 4'h5;
		@(posedge clk);
		txDone <= 4'h0;
		txUnderflow <= 4'h0;
		settle;
		rd(OFF_TX_FLG, 32'h42);
		rd(OFF_MAIN_EV, 32'h04);
		txStatusRead <= 4'h2;
		@(posedge clk);
		txStatusRead <= 4'h0;
		settle;
		rd(OFF_TX_FLG, 32'h40);
		rd(OFF_MAIN_EV, 32'h04);
		txStatusRead <= 4'h4;
		@(posedge clk);
		txStatusRead <= 4'h0;
		settle;
		rd(OFF_MAIN_EV, 32'h00);
		wr(OFF_TX_MSK, 32'h00);
		txDone <= 4'h8;
		@(posedge clk);
		txDone <= 4'h0;
		settle;
		rd(OFF_TX_FLG, 32'h08);
		rd(OFF_MAIN_EV, 32'h00);
	endtask : t_transmit

	task automatic t_receive;
		wr(OFF_RX_MSK, 32'hFF);
		rxErrOrLast <= 4'h1;
		rxOverrun <= 4'h8;
		@(posedge clk);
		rxErrOrLast <= 4'h0;
		rxOverrun <= 4'h0;
		settle;
		rd(OFF_RX_FLG, 32'h81);
		rd(OFF_RX_FLG, 32'h01);
		rd(OFF_MAIN_EV, 32'h40);
		rxStatusRead <= 4'h1;
		@(posedge clk);
		rxStatusRead <= 4'h0;
		settle;
		rd(OFF_RX_FLG, 32'h00);
		rd(OFF_MAIN_EV, 32'h00);
	endtask : t_receive

	task automatic t_secondary;
		wr(OFF_SEC_MSK, 32'hFE);
		wakePend <= 1'b1;
		wakeIssued <= 1'b1;
		eopSeen <= 1'b1;
		dmaPend <= 1'b1;
		@(posedge clk);
		wakeIssued <= 1'b0;
		eopSeen <= 1'b0;
		settle;
		rd(OFF_MAIN_EV, 32'h02);
		rd(OFF_SEC_FLG, 32'h0E);
		rd(OFF_SEC_FLG, 32'h06);
		rd(OFF_MAIN_EV, 32'h00);
		wakePend <= 1'b0;
		dmaPend <= 1'b0;
		settle;
		rd(OFF_SEC_FLG, 32'h00);
	endtask : t_secondary

	task automatic t_line_timers;
		nodeState <= NODE_SUSPEND;
		lineIdle <= 1'b1;
		@(posedge clk);
		lineIdle <= 1'b0;
		settle;
		rd(OFF_SEC_FLG, 32'h80);
		nodeState <= 2'h2;
		lineIdle <= 1'b1;
		repeat (60) @(posedge clk);
		lineIdle <= 1'b0;
		settle;
		rd(OFF_SEC_FLG, 32'h30);
		rd(OFF_SEC_FLG, 32'h00);
		lineSe0 <= 1'b1;
		repeat (SE0_CYC + 5) @(posedge clk);
		lineSe0 <= 1'b0;
		settle;
		rd(OFF_SEC_FLG, 32'h40);
		// firmware answer to a bus reset: park the node in reset, then go operational
		nodeState <= 2'h0;
		repeat (NODE_RST_CYC) @(posedge clk);
		nodeState <= 2'h2;
		rd(OFF_SEC_FLG, 32'h00);
	endtask : t_line_timers

	// reset in mid-run with flags and masks left set by earlier scenarios
	task automatic t_reset;
		frameUpdate <= 1'b1;
		@(posedge clk);
		frameUpdate <= 1'b0;
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		chk({31'h0, irq}, 32'h0);
		rd(OFF_MAIN_EV, 32'h00);
		rd(OFF_SEC_MSK, 32'h00);
		rd(OFF_MAIN_MSK, 32'h00);
		rd(OFF_TX_FLG, 32'h00);
	endtask : t_reset

	initial begin
		{psel, penable, pwrite, setFifo, readFifo, setNoAck, readNoAck, dmaPend} = '0;
		{wakeIssued, wakePend, frameUpdate, eopSeen, lineIdle, lineSe0} = '0;
		{paddr, pwdata, nodeState} = '0;
		{txDone, txUnderflow, txStatusRead, rxErrOrLast, rxOverrun, rxStatusRead} = '0;
		unlockedFlag = 1'b1;
		failures = 0;
		cmp_count = 0;
		reset = 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		t_registers;
		t_frame_lock;
		t_fifo_nak;
		t_transmit;
		t_receive;
		t_secondary;
		t_line_timers;
		t_reset;
		give_verdict;
	end
endmodule : usb_node_event_aggregator_bench
